// ==== hw/embedded_memory_block.sv ====
// Dual-port RAM / ROM / FIFO / content-addressable memory block
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`include "ram_cam_defines.svh"
`timescale 1ns/1ps
module embedded_memory_block
	import ram_cam_pkg::*;
(
	// Clock and resets
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic chip_rst_i,
	input wire logic global_clr_i,
	// Write side
	input wire logic wr_ce_i,
	input wire logic wr_aclr_i,
	input wire logic wr_en_i,
	input wire logic [`MEM_AW-1:0] wr_addr_i,
	input wire logic [`MEM_DW-1:0] wr_data_i,
	input wire logic [`MEM_DW-1:0] wr_dontcare_i,
	// Read side
	input wire logic rd_ce_i,
	input wire logic rd_aclr_i,
	input wire logic read_strobe_i,
	input wire logic [`MEM_AW-1:0] rd_addr_i,
	input wire logic cam_search_i,
	input wire logic [`MEM_DW-1:0] cam_key_i,
	output logic [`MEM_DW-1:0] rd_data_o,
	output logic rd_valid_o,
	// Search results and CAM entry write busy
	output logic match_found_o,
	output logic [`MEM_AW-1:0] match_addr_o,
	output logic [`VEC_W-1:0] match_vec_o,
	output logic match_vec_valid_o,
	output logic match_vec_half_o,
	output logic cam_busy_o,
	// FIFO status
	output logic fifo_full_o,
	output logic fifo_empty_o,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	function automatic logic entry_hit(input logic [`MEM_DW-1:0] d,
		input logic [`MEM_DW-1:0] c, input logic [`MEM_DW-1:0] k);
		return &(~(d ^ k) | ~c);
	endfunction : entry_hit

	function automatic logic [31:0] byte_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : byte_merge

	logic wr_clr;
	logic rd_clr;
	ctrl_type ctrl_ff;
	logic [`MEM_AW-1:0] load_idx_ff;
	logic ack_ff;
	logic [31:0] dat_o_ff;
	logic [31:0] nxt_dat_o;
	logic bus_req;
	logic bus_wr;
	logic [`MEM_DW-1:0] mem_ff [`MEM_DEPTH];
	logic [`MEM_DW-1:0] care_ff [`MEM_DEPTH];
	logic [`MEM_DEPTH-1:0] valid_ff;
	logic wr_en_ff;
	logic [`MEM_AW-1:0] wr_addr_ff;
	logic [`MEM_DW-1:0] wr_data_ff;
	logic [`MEM_DW-1:0] wr_mask_ff;
	logic [`MEM_AW:0] wr_ptr_ff;
	logic [`MEM_AW:0] rd_ptr_ff;
	logic [`MEM_AW:0] fifo_count;
	cam_wr_type cam_st_ff;
	logic rd_en_ff;
	logic [`MEM_AW-1:0] rd_addr_ff;
	logic search_ff;
	logic [`MEM_DW-1:0] key_ff;
	logic [`MEM_AW-1:0] arr_addr;
	logic rd_take;
	logic [`MEM_DW-1:0] rd_data_ff;
	logic rd_valid_ff;
	logic [`MEM_DW-1:0] rd_pipe_ff;
	logic rd_pvalid_ff;
	logic [`MEM_DEPTH-1:0] hit;
	logic [`MEM_AW-1:0] hit_enc;
	logic found_ff;
	logic [`MEM_AW-1:0] addr_ff;
	logic [`VEC_W-1:0] vec_ff;
	logic [`VEC_W-1:0] hit_hi_ff;
	logic vec_valid_ff;
	logic vec_half_ff;
	logic vec_pend_ff;

	assign wr_clr = wr_aclr_i | global_clr_i | chip_rst_i;
	assign rd_clr = rd_aclr_i | global_clr_i | chip_rst_i;

	// Register bus: ack one cycle after the request, write at the ack edge
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign bus_wr = bus_req & wb_we_i & ack_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_o_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= bus_req & ~ack_ff;
			if (bus_req & ~ack_ff) begin
				dat_o_ff <= nxt_dat_o;
			end
		end
	end

	always_comb begin
		nxt_dat_o = 32'h0000_0000;
		case (wb_adr_i)
			`OFS_CTRL: nxt_dat_o = {28'h0000000, ctrl_ff};
			`OFS_STATUS: begin
				nxt_dat_o[`STAT_EMPTY_BIT] = fifo_empty_o;
				nxt_dat_o[`STAT_FULL_BIT] = fifo_full_o;
				nxt_dat_o[`STAT_BUSY_BIT] = cam_busy_o;
				nxt_dat_o[`STAT_COUNT_LSB +: `MEM_AW+1] = fifo_count;
			end
			`OFS_LOAD_ADDR: nxt_dat_o = {27'h0000000, load_idx_ff};
			`OFS_LOAD_DATA: nxt_dat_o = mem_ff[load_idx_ff];
			`OFS_LOAD_MASK: nxt_dat_o = ~care_ff[load_idx_ff];
			default: nxt_dat_o = 32'h0000_0000;
		endcase
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_o_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= ctrl_type'(`CTRL_RESET);
			load_idx_ff <= 5'h00;
		end else if (bus_wr && wb_sel_i[0]) begin
			if (wb_adr_i == `OFS_CTRL) begin
				ctrl_ff <= ctrl_type'(wb_dat_i[`CTRL_W-1:0]);
			end
			if (wb_adr_i == `OFS_LOAD_ADDR) begin
				load_idx_ff <= wb_dat_i[`MEM_AW-1:0];
			end
		end
	end

	// Write-side input registers
	always_ff @(posedge clk_i or posedge wr_clr) begin
		if (wr_clr) begin
			wr_en_ff <= 1'b0;
			wr_addr_ff <= 5'h00;
			wr_data_ff <= 32'h0000_0000;
			wr_mask_ff <= 32'h0000_0000;
		end else if (wr_ce_i) begin
			wr_en_ff <= wr_en_i;
			wr_addr_ff <= wr_addr_i;
			wr_data_ff <= wr_data_i;
			wr_mask_ff <= wr_dontcare_i;
		end
	end

	assign fifo_count = wr_ptr_ff - rd_ptr_ff;
	assign fifo_full_o = fifo_count == `FIFO_FULL_COUNT;
	assign fifo_empty_o = fifo_count == 6'h00;
	assign cam_busy_o = cam_st_ff != CW_IDLE;

	// Array, FIFO write pointer and entry write sequencer
	always_ff @(posedge clk_i or posedge wr_clr) begin
		if (wr_clr) begin
			for (int i = 0; i < `MEM_DEPTH; i++) begin
				mem_ff[i] <= 32'h0000_0000;
				care_ff[i] <= 32'hFFFF_FFFF;
			end
			valid_ff <= 32'h0000_0000;
			wr_ptr_ff <= 6'h00;
			cam_st_ff <= CW_IDLE;
		end else begin
			if (wr_ce_i) begin
				case (ctrl_ff.mode)
					MODE_RAM: begin
						if (wr_en_ff) begin
							mem_ff[wr_addr_ff] <= wr_data_ff;
						end
					end
					MODE_FIFO: begin
						if (wr_en_ff && !fifo_full_o) begin
							mem_ff[wr_ptr_ff[`MEM_AW-1:0]] <= wr_data_ff;
							wr_ptr_ff <= wr_ptr_ff + 6'h01;
						end
					end
					MODE_CAM: begin
						case (cam_st_ff)
							CW_IDLE: begin
								if (wr_en_ff) begin
									mem_ff[wr_addr_ff] <= wr_data_ff;
									care_ff[wr_addr_ff] <= 32'hFFFF_FFFF;
									valid_ff[wr_addr_ff] <= 1'b1;
									// Third cycle only when don't-care bits exist
									cam_st_ff <= (|wr_mask_ff) ? CW_MASK : CW_WAIT;
								end
							end
							CW_MASK: begin
								care_ff[wr_addr_ff] <= ~wr_mask_ff;
								cam_st_ff <= CW_WAIT;
							end
							CW_WAIT: begin
								// A held enable must not start a second write
								if (!wr_en_ff) begin
									cam_st_ff <= CW_IDLE;
								end
							end
							default: cam_st_ff <= CW_IDLE;
						endcase
					end
					default: ;
				endcase
			end
			// Preload from the bus wins over a user write in the same cycle
			if (bus_wr && wb_adr_i == `OFS_LOAD_DATA) begin
				mem_ff[load_idx_ff] <= byte_merge(mem_ff[load_idx_ff], wb_dat_i, wb_sel_i);
				valid_ff[load_idx_ff] <= 1'b1;
			end
			if (bus_wr && wb_adr_i == `OFS_LOAD_MASK) begin
				care_ff[load_idx_ff] <= ~byte_merge(~care_ff[load_idx_ff], wb_dat_i, wb_sel_i);
			end
		end
	end

	// Read-side input registers
	always_ff @(posedge clk_i or posedge rd_clr) begin
		if (rd_clr) begin
			rd_en_ff <= 1'b0;
			rd_addr_ff <= 5'h00;
			search_ff <= 1'b0;
			key_ff <= 32'h0000_0000;
		end else if (rd_ce_i) begin
			rd_en_ff <= read_strobe_i;
			rd_addr_ff <= rd_addr_i;
			search_ff <= cam_search_i;
			key_ff <= cam_key_i;
		end
	end

	assign arr_addr = (ctrl_ff.mode == MODE_FIFO) ? rd_ptr_ff[`MEM_AW-1:0] : rd_addr_ff;
	assign rd_take = rd_en_ff && ctrl_ff.mode != MODE_CAM
		&& (ctrl_ff.mode != MODE_FIFO || !fifo_empty_o);

	// Read data register and optional pipeline stage
	always_ff @(posedge clk_i or posedge rd_clr) begin
		if (rd_clr) begin
			rd_data_ff <= 32'h0000_0000;
			rd_valid_ff <= 1'b0;
			rd_pipe_ff <= 32'h0000_0000;
			rd_pvalid_ff <= 1'b0;
			rd_ptr_ff <= 6'h00;
		end else if (rd_ce_i) begin
			rd_valid_ff <= rd_take;
			if (rd_take) begin
				rd_data_ff <= mem_ff[arr_addr];
			end
			if (rd_take && ctrl_ff.mode == MODE_FIFO) begin
				rd_ptr_ff <= rd_ptr_ff + 6'h01;
			end
			rd_pipe_ff <= rd_data_ff;
			rd_pvalid_ff <= rd_valid_ff;
		end
	end

	assign rd_data_o = ctrl_ff.out_reg ? rd_pipe_ff : rd_data_ff;
	assign rd_valid_o = ctrl_ff.out_reg ? rd_pvalid_ff : rd_valid_ff;

	// Parallel compare of every entry
	generate
		for (genvar g = 0; g < `MEM_DEPTH; g++) begin : g_cmp
			assign hit[g] = valid_ff[g] & entry_hit(mem_ff[g], care_ff[g], key_ff);
		end
	endgenerate

	// Lowest matching entry wins; duplicates are not resolved further
	always_comb begin
		hit_enc = 5'h00;
		for (int i = `MEM_DEPTH - 1; i >= 0; i--) begin
			if (hit[i]) begin
				hit_enc = i[`MEM_AW-1:0];
			end
		end
	end

	always_ff @(posedge clk_i or posedge rd_clr) begin
		if (rd_clr) begin
			found_ff <= 1'b0;
			addr_ff <= 5'h00;
			vec_ff <= 16'h0000;
			hit_hi_ff <= 16'h0000;
			vec_valid_ff <= 1'b0;
			vec_half_ff <= 1'b0;
			vec_pend_ff <= 1'b0;
		end else if (rd_ce_i) begin
			if (vec_pend_ff) begin
				vec_ff <= hit_hi_ff;
				vec_half_ff <= 1'b1;
				vec_valid_ff <= 1'b1;
				vec_pend_ff <= 1'b0;
			end else if (search_ff && ctrl_ff.mode == MODE_CAM) begin
				if (ctrl_ff.cam_encoded) begin
					found_ff <= |hit;
					addr_ff <= hit_enc;
					vec_valid_ff <= 1'b0;
					vec_half_ff <= 1'b0;
				end else begin
					vec_ff <= hit[`VEC_W-1:0];
					hit_hi_ff <= hit[`MEM_DEPTH-1:`VEC_W];
					vec_valid_ff <= 1'b1;
					vec_half_ff <= 1'b0;
					vec_pend_ff <= 1'b1;
				end
			end else begin
				vec_valid_ff <= 1'b0;
				vec_half_ff <= 1'b0;
			end
		end
	end

	assign match_found_o = found_ff;
	assign match_addr_o = addr_ff;
	assign match_vec_o = vec_ff;
	assign match_vec_valid_o = vec_valid_ff;
	assign match_vec_half_o = vec_half_ff;

endmodule : embedded_memory_block

// ==== hw/ram_cam_defines.svh ====
// Offsets, field positions, reset values and sizes of the memory block
`ifndef RAM_CAM_DEFINES_SVH
`define RAM_CAM_DEFINES_SVH
`define MEM_DEPTH 32
`define MEM_AW 5
`define MEM_DW 32
`define VEC_W 16
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_LOAD_ADDR 8'h08
`define OFS_LOAD_DATA 8'h0C
`define OFS_LOAD_MASK 8'h10
`define CTRL_W 4
`define CTRL_RESET 4'h8
`define STAT_EMPTY_BIT 0
`define STAT_FULL_BIT 1
`define STAT_BUSY_BIT 2
`define STAT_COUNT_LSB 8
`define FIFO_FULL_COUNT 6'h20
`endif

// ==== hw/ram_cam_pkg.sv ====
// Types shared by the memory block
package ram_cam_pkg;
	typedef enum logic [1:0] {
		MODE_RAM = 2'b00,
		MODE_ROM = 2'b01,
		MODE_FIFO = 2'b10,
		MODE_CAM = 2'b11
	} mode_type;
	typedef enum logic [1:0] {
		CW_IDLE = 2'b00,
		CW_MASK = 2'b01,
		CW_WAIT = 2'b10
	} cam_wr_type;
	typedef struct packed {
		logic cam_encoded;
		logic out_reg;
		mode_type mode;
	} ctrl_type;
endpackage : ram_cam_pkg

// ==== dv/embedded_memory_block_chk.sv ====
// Concurrent checks on the memory block ports
`timescale 1ns/1ps
`include "ram_cam_defines.svh"
module embedded_memory_block_chk (
	// Clock and clears
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic chip_rst_i,
	input wire logic global_clr_i,
	input wire logic wr_aclr_i,
	input wire logic rd_aclr_i,
	// Requests
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic rd_ce_i,
	input wire logic read_strobe_i,
	input wire logic cam_search_i,
	input wire logic wr_en_i,
	// Answers
	input wire logic wb_ack_o,
	input wire logic rd_valid_o,
	input wire logic match_found_o,
	input wire logic [`MEM_AW-1:0] match_addr_o,
	input wire logic match_vec_valid_o,
	input wire logic match_vec_half_o,
	input wire logic cam_busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || chip_rst_i || global_clr_i || wr_aclr_i || rd_aclr_i);
	ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single pulse");
	// Valid comes two edges after the strobe is taken, three with the output stage
	read_source_a: assert property (rd_valid_o |-> $past(read_strobe_i, 2) || $past(read_strobe_i, 3))
		else $error("read valid without a read");
	vec_first_a: assert property ($rose(match_vec_valid_o) |-> !match_vec_half_o && $past(cam_search_i, 2))
		else $error("match vector starts wrong");
	vec_second_a: assert property (match_vec_valid_o && !match_vec_half_o && rd_ce_i |=> match_vec_valid_o && match_vec_half_o)
		else $error("upper half missing");
	vec_end_a: assert property (match_vec_valid_o && match_vec_half_o && rd_ce_i |=> !match_vec_half_o)
		else $error("upper half too long");
	busy_cause_a: assert property ($rose(cam_busy_o) |-> $past(wr_en_i) || $past(wr_en_i, 2))
		else $error("busy without a write");
	busy_bound_a: assert property ($rose(cam_busy_o) |-> ##[1:8] !cam_busy_o)
		else $error("entry write never ends");
	result_hold_a: assert property ($changed(match_found_o) || $changed(match_addr_o) |-> $past(cam_search_i, 2))
		else $error("search result moved unasked");
	cover property ($rose(match_found_o));
	cover property (match_vec_valid_o && match_vec_half_o);
	cover property ($fell(cam_busy_o));
endmodule : embedded_memory_block_chk
bind embedded_memory_block embedded_memory_block_chk i_chk (.clk_i, .rst_i, .chip_rst_i,
	.global_clr_i, .wr_aclr_i, .rd_aclr_i, .wb_cyc_i, .wb_stb_i, .rd_ce_i, .read_strobe_i,
	.cam_search_i, .wr_en_i, .wb_ack_o, .rd_valid_o, .match_found_o, .match_addr_o,
	.match_vec_valid_o, .match_vec_half_o, .cam_busy_o);

// ==== dv/fabric_writer.sv ====
// Fabric-side user logic that drives the write port
`timescale 1ns/1ps
module fabric_writer (
	// Clock and requests
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic [4:0] addr_i,
	input wire logic [31:0] data_i,
	input wire logic [31:0] mask_i,
	// Write port
	output logic wr_en_o,
	output logic [4:0] wr_addr_o,
	output logic [31:0] wr_data_o,
	output logic [31:0] wr_dontcare_o
);
	logic [1:0] cnt_ff;
	// Data goes stale on release so nothing leans on a held value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff <= 2'h0;
			wr_en_o <= 1'h0;
			wr_addr_o <= 5'h00;
			wr_data_o <= 32'h0;
			wr_dontcare_o <= 32'h0;
		end else if (req_i && cnt_ff == 2'h0) begin
			cnt_ff <= (mask_i != 32'h0) ? 2'h3 : 2'h2;
			wr_en_o <= 1'h1;
			wr_addr_o <= addr_i;
			wr_data_o <= data_i;
			wr_dontcare_o <= mask_i;
		end else if (cnt_ff != 2'h0) begin
			cnt_ff <= cnt_ff - 2'h1;
			wr_en_o <= (cnt_ff != 2'h1);
			wr_data_o <= (cnt_ff == 2'h1) ? ~wr_data_o : wr_data_o;
		end
	end
endmodule : fabric_writer

// ==== dv/embedded_memory_block_tb.sv ====
// Self-checking bench for the memory block
`timescale 1ns/1ps
`include "ram_cam_defines.svh"
module embedded_memory_block_tb
	import ram_cam_pkg::*;
;
	logic clk_i = 1'h0, rst_i = 1'h1, global_clr_i = 1'h1, wr_ce_i = 1'h1, req = 1'h0;
	logic rd_ce_i = 1'h1, wr_aclr_i = 1'h0, rd_aclr_i = 1'h0, chip_rst_i = 1'h0;
	logic fifo_full_o, fifo_empty_o;
	logic read_strobe_i = 1'h0, cam_search_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
	logic wb_we_i = 1'h0, wr_en_i, rd_valid_o, match_found_o, match_vec_valid_o;
	logic match_vec_half_o, wb_ack_o;
	logic [4:0] rd_addr_i = 5'h00, w_addr = 5'h00, wr_addr_i, match_addr_o;
	logic [7:0] wb_adr_i = 8'h00;
	logic [15:0] match_vec_o;
	logic [31:0] cam_key_i = 32'h0, w_data = 32'h0, w_mask = 32'h0, wb_dat_i = 32'h0, v;
	logic [31:0] wr_data_i, wr_dontcare_i, rd_data_o, wb_dat_o;
	int failures = 0, compares = 0;
	always #4 clk_i = ~clk_i;
	fabric_writer i_user (.clk_i, .rst_i, .req_i(req), .addr_i(w_addr), .data_i(w_data),
		.mask_i(w_mask), .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i), .wr_data_o(wr_data_i),
		.wr_dontcare_o(wr_dontcare_i));
	embedded_memory_block i_dut (.clk_i, .rst_i, .chip_rst_i, .global_clr_i, .wr_ce_i,
		.wr_aclr_i, .wr_en_i, .wr_addr_i, .wr_data_i, .wr_dontcare_i, .rd_ce_i,
		.rd_aclr_i, .read_strobe_i, .rd_addr_i, .cam_search_i, .cam_key_i, .rd_data_o,
		.rd_valid_o, .match_found_o, .match_addr_o, .match_vec_o, .match_vec_valid_o,
		.match_vec_half_o, .cam_busy_o(), .fifo_full_o, .fifo_empty_o, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report;
		if (failures == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report
	task automatic await(input logic pick, output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((pick ? rd_valid_o : wb_ack_o) !== 1'h1 && n < 8);
		if ((pick ? rd_valid_o : wb_ack_o) !== 1'h1) begin
			failures++;
			$display("CHECK FAILED at %0t: no answer", $time);
			final_report();
		end
	endtask : await
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		await(1'h0, n);
		v = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		wb_we_i <= 1'h0;
	endtask : wb
	task automatic set_mode(input ctrl_type c);
		wb(1'h1, `OFS_CTRL, {28'h0, c});
	endtask : set_mode
	task automatic rd(input logic [4:0] a, input logic [31:0] exp, input int lat);
		int n;
		@(posedge clk_i);
		read_strobe_i <= 1'h1;
		rd_addr_i <= a;
		@(posedge clk_i);
		read_strobe_i <= 1'h0;
		// Latency counts edges after the strobe is taken, up to the edge that sees valid
		await(1'h1, n);
		chk(rd_data_o, exp);
		chk(n, lat);
	endtask : rd
	// Fabric writer holds the enable itself; four edges cover its longest write
	task automatic put(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m);
		@(posedge clk_i);
		req <= 1'h1;
		w_addr <= a;
		w_data <= d;
		w_mask <= m;
		@(posedge clk_i);
		req <= 1'h0;
		repeat (4) @(posedge clk_i);
	endtask : put
	task automatic find(input logic u, input logic [31:0] k, input logic [31:0] e0,
		input logic [31:0] e1);
		@(posedge clk_i);
		cam_search_i <= 1'h1;
		cam_key_i <= k;
		@(posedge clk_i);
		cam_search_i <= 1'h0;
		@(posedge clk_i);
		#1;
		if (u) begin
			chk({match_vec_valid_o, match_vec_half_o, match_vec_o}, e0);
			@(posedge clk_i);
			#1;
			chk({match_vec_valid_o, match_vec_half_o, match_vec_o}, e1);
		end else begin
			chk({match_found_o, match_addr_o} & e1[5:0], e0);
		end
	endtask : find
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		global_clr_i <= 1'h0;
		wb(1'h0, `OFS_CTRL, 32'h0);
		chk(v, {28'h0, `CTRL_RESET});
		wb(1'h0, `OFS_STATUS, 32'h0);
		chk(v, 32'h1);
		chk({fifo_full_o, fifo_empty_o}, 32'h1);
		wb(1'h1, 8'hFC, 32'hFFFF_FFFF);
		wb(1'h0, 8'hFC, 32'h0);
		chk(v, 32'h0);
		set_mode(ctrl_type'{1'h1, 1'h0, MODE_CAM});
		put(5'h0C, 32'hA5A5_0F0F, 32'h0);
		put(5'h14, 32'h1234_5678, 32'h0000_00FF);
		wb(1'h1, `OFS_LOAD_ADDR, 32'h3);
		wb(1'h1, `OFS_LOAD_DATA, 32'hCAFE_0001);
		find(1'h0, 32'hA5A5_0F0F, 32'h2C, 32'h3F);
		find(1'h0, 32'h1234_56AB, 32'h34, 32'h3F);
		find(1'h0, 32'hCAFE_0001, 32'h23, 32'h3F);
		find(1'h0, 32'h0BAD_F00D, 32'h00, 32'h20);
		set_mode(ctrl_type'{1'h0, 1'h0, MODE_CAM});
		put(5'h1C, 32'hA5A5_0F0F, 32'h0);
		find(1'h1, 32'hA5A5_0F0F, 32'h0002_1000, 32'h0003_1000);
		// Each put holds the enable two cycles, so every word is queued twice
		set_mode(ctrl_type'{1'h1, 1'h0, MODE_FIFO});
		put(5'h00, 32'hF1F0_0001, 32'h0);
		put(5'h00, 32'hF1F0_0002, 32'h0);
		wb(1'h0, `OFS_STATUS, 32'h0);
		chk(v, 32'h0000_0400);
		chk({fifo_full_o, fifo_empty_o}, 32'h0);
		rd(5'h00, 32'hF1F0_0001, 2);
		rd(5'h00, 32'hF1F0_0001, 2);
		rd(5'h00, 32'hF1F0_0002, 2);
		set_mode(ctrl_type'{1'h1, 1'h0, MODE_ROM});
		put(5'h08, 32'h8888_0008, 32'h0);
		rd(5'h08, 32'h0, 2);
		set_mode(ctrl_type'{1'h1, 1'h0, MODE_RAM});
		put(5'h05, 32'h5555_0005, 32'h0);
		fork
			put(5'h06, 32'h6666_0006, 32'h0);
			rd(5'h05, 32'h5555_0005, 2);
		join
		set_mode(ctrl_type'{1'h1, 1'h1, MODE_RAM});
		rd(5'h06, 32'h6666_0006, 3);
		wr_ce_i <= 1'h0;
		put(5'h07, 32'h7777_0007, 32'h0);
		wr_ce_i <= 1'h1;
		rd(5'h07, 32'h0, 3);
		// A strobe offered while the read side is frozen must be lost
		rd_ce_i <= 1'h0;
		read_strobe_i <= 1'h1;
		rd_addr_i <= 5'h05;
		@(posedge clk_i);
		read_strobe_i <= 1'h0;
		repeat (3) @(posedge clk_i);
		chk(rd_valid_o, 32'h0);
		chk(rd_data_o, 32'h0);
		rd_ce_i <= 1'h1;
		rd(5'h05, 32'h5555_0005, 3);
		rd_aclr_i <= 1'h1;
		@(posedge clk_i);
		rd_aclr_i <= 1'h0;
		chk(rd_data_o, 32'h0);
		rd(5'h05, 32'h5555_0005, 3);
		chip_rst_i <= 1'h1;
		@(posedge clk_i);
		chip_rst_i <= 1'h0;
		rd(5'h05, 32'h0, 3);
		put(5'h05, 32'h5555_0005, 32'h0);
		rd(5'h05, 32'h5555_0005, 3);
		wr_aclr_i <= 1'h1;
		@(posedge clk_i);
		wr_aclr_i <= 1'h0;
		rd(5'h05, 32'h0, 3);
		put(5'h05, 32'h5555_0005, 32'h0);
		global_clr_i <= 1'h1;
		@(posedge clk_i);
		global_clr_i <= 1'h0;
		rd(5'h05, 32'h0, 3);
		final_report();
	end
endmodule : embedded_memory_block_tb
